// file: hdl/mtxci_params.svh
`ifndef MTXCI_PARAMS_SVH
`define MTXCI_PARAMS_SVH
`define MTXCI_APB_AW 8
`define MTXCI_OFF_CTRL0 8'h00
`define MTXCI_OFF_CTRL1 8'h04
`define MTXCI_OFF_STAT0 8'h08
`define MTXCI_OFF_STAT1 8'h0C
`define MTXCI_OFF_IRQ 8'h10
`define MTXCI_OFF_MASK 8'h14
`define MTXCI_CTRL_WIDE_BIT 0
`define MTXCI_CTRL_HALF_BIT 1
`define MTXCI_CTRL_SPEED_LSB 2
`define MTXCI_CTRL_MODE_LSB 4
`define MTXCI_CTRL_SLOT_BIT 7
`define MTXCI_CTRL_RESET 32'h0000_0000
`define MTXCI_IRQ_BITS 4
`define MTXCI_EV_DONE0 0
`define MTXCI_EV_ABORT0 1
`define MTXCI_EV_DONE1 2
`define MTXCI_EV_ABORT1 3
`define MTXCI_STD_GAP 8'h0C
`define MTXCI_COL_SLOT 8'h40
`define MTXCI_DIV_1000 8'h01
`define MTXCI_DIV_100 8'h0A
`define MTXCI_DIV_10 8'h64
`define MTXCI_BAD_SYM 8'hFE
`endif

// file: hdl/mtxci_pkg.sv
package mtxci_pkg;
  typedef enum logic [1:0] {MTXCI_SPD_10, MTXCI_SPD_100, MTXCI_SPD_1000, MTXCI_SPD_TRI} mtxci_speed_t;
  typedef enum logic [2:0] {MTXCI_PHY_GMII, MTXCI_PHY_MII, MTXCI_PHY_RGMII, MTXCI_PHY_SGMII,
    MTXCI_PHY_PCS} mtxci_phy_t;
  typedef struct packed {
    logic wide;
    logic half_duplex;
    mtxci_speed_t speed;
    mtxci_phy_t phy;
    logic col_inject;
  } mtxci_cfg_t;
  typedef struct packed {
    logic [15:0] data;
    logic valid;
    logic odd;
    logic first;
    logic [7:0] gap;
    logic abort;
  } mtxci_client_t;
  typedef struct packed {
    logic ack;
    logic collision;
    logic resend;
  } mtxci_answer_t;
  typedef struct packed {
    logic [7:0] data;
    logic en;
    logic err;
  } mtxci_line_t;
endpackage

// file: hdl/mtxci_engine.sv
`timescale 1ns/1ns
`include "mtxci_params.svh"
module mtxci_engine
  import mtxci_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire mtxci_cfg_t cfg_in,
  input wire mtxci_client_t client_in,
  output mtxci_answer_t answer_out,
  output mtxci_line_t line_out,
  output logic line_clk_out,
  output logic done_out,
  output logic abort_out,
  output logic busy_out
);
  typedef enum logic [1:0] {MTXCI_IDLE, MTXCI_SEND, MTXCI_GAP} mtxci_eng_state_t;
  typedef struct packed {
    mtxci_eng_state_t st;
    logic [7:0] hi_byte;
    logic hi_pending;
    logic corrupt;
    logic [7:0] count;
    logic [7:0] slot;
    logic [7:0] div;
    logic lclk;
    mtxci_answer_t ans;
    mtxci_line_t line;
    logic done;
    logic abort;
  } mtxci_eng_t;
  mtxci_eng_t s_reg, s_next;

  function automatic logic [7:0] gap_len(input mtxci_cfg_t c, input logic [7:0] adj);
    gap_len = (!c.half_duplex && adj > `MTXCI_STD_GAP) ? adj : `MTXCI_STD_GAP;
  endfunction
  function automatic logic [7:0] clk_div(input mtxci_speed_t s);
    unique case (s)
      MTXCI_SPD_10: clk_div = `MTXCI_DIV_10;
      MTXCI_SPD_100: clk_div = `MTXCI_DIV_100;
      default: clk_div = `MTXCI_DIV_1000;
    endcase
  endfunction

  logic wide_ok;
  assign wide_ok = cfg_in.wide && (cfg_in.phy == MTXCI_PHY_PCS);

  always_comb begin
    s_next = s_reg;
    s_next.ans = '0;
    s_next.done = 1'b0;
    s_next.abort = 1'b0;
    s_next.line.en = 1'b0;
    s_next.line.err = 1'b0;
    if (s_reg.div >= clk_div(cfg_in.speed) - 8'h01) begin
      s_next.div = 8'h00;
      s_next.lclk = ~s_reg.lclk;
    end else begin
      s_next.div = s_reg.div + 8'h01;
    end
    unique case (s_reg.st)
      MTXCI_IDLE: begin
        // The first word is taken at the edge that shows the accept, so the client can react to it.
        if (client_in.valid) begin
          s_next.ans.ack = 1'b1;
          s_next.st = MTXCI_SEND;
          s_next.corrupt = client_in.abort;
          s_next.slot = 8'h00;
          s_next.hi_pending = 1'b0;
        end
      end
      MTXCI_SEND: begin
        s_next.slot = s_reg.slot + 8'h01;
        if (client_in.abort) s_next.corrupt = 1'b1;
        if (s_reg.hi_pending) begin
          s_next.line.en = 1'b1;
          s_next.line.data = s_reg.hi_byte;
          s_next.line.err = s_reg.corrupt | client_in.abort;
          s_next.hi_pending = 1'b0;
        end else if (client_in.valid) begin
          s_next.line.en = 1'b1;
          s_next.line.data = client_in.data[7:0];
          s_next.line.err = s_reg.corrupt | client_in.abort;
          s_next.hi_byte = client_in.data[15:8];
          s_next.hi_pending = wide_ok && !client_in.odd;
        end else begin
          s_next.st = MTXCI_GAP;
          s_next.count = gap_len(cfg_in, client_in.gap);
          s_next.done = 1'b1;
          s_next.abort = s_reg.corrupt;
          s_next.corrupt = 1'b0;
        end
        if (s_reg.corrupt && s_reg.line.en) begin
          s_next.line.data = `MTXCI_BAD_SYM;
          s_next.line.err = 1'b1;
        end
        if (cfg_in.half_duplex && cfg_in.col_inject && s_reg.slot == `MTXCI_COL_SLOT) begin
          s_next.ans.collision = 1'b1;
          s_next.ans.resend = 1'b1;
          s_next.abort = 1'b1;
          s_next.st = MTXCI_GAP;
          s_next.hi_pending = 1'b0;
          s_next.count = gap_len(cfg_in, client_in.gap);
        end
      end
      MTXCI_GAP: begin
        if (s_reg.count <= 8'h01) s_next.st = MTXCI_IDLE;
        else s_next.count = s_reg.count - 8'h01;
      end
      default: s_next.st = MTXCI_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign answer_out = s_reg.ans;
  assign line_out = s_reg.line;
  assign line_clk_out = s_reg.lclk;
  assign done_out = s_reg.done;
  assign abort_out = s_reg.abort;
  assign busy_out = (s_reg.st != MTXCI_IDLE);
endmodule // mtxci_engine

// file: hdl/mtxci_top.sv
`timescale 1ns/1ns
`include "mtxci_params.svh"
module mtxci_top
  import mtxci_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`MTXCI_APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mtxci_client_t tx_client0_in,
  input wire mtxci_client_t tx_client1_in,
  output mtxci_answer_t tx_answer0_out,
  output mtxci_answer_t tx_answer1_out,
  output mtxci_line_t tx_line0_out,
  output mtxci_line_t tx_line1_out,
  output logic tx_line_clk0_out,
  output logic tx_line_clk1_out,
  output logic irq_out
);
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [`MTXCI_IRQ_BITS-1:0] irq_stat;
    logic [`MTXCI_IRQ_BITS-1:0] irq_mask;
    logic irq;
  } mtxci_top_state_t;
  mtxci_top_state_t s_reg, s_next;

  mtxci_cfg_t cfg0, cfg1;
  logic done0, abort0, busy0, done1, abort1, busy1;
  logic [`MTXCI_IRQ_BITS-1:0] events;

  function automatic mtxci_cfg_t decode_cfg(input logic [7:0] c);
    mtxci_cfg_t r;
    r.wide = c[`MTXCI_CTRL_WIDE_BIT];
    r.speed = mtxci_speed_t'(c[`MTXCI_CTRL_SPEED_LSB +: 2]);
    r.phy = mtxci_phy_t'(c[`MTXCI_CTRL_MODE_LSB +: 3]);
    r.half_duplex = c[`MTXCI_CTRL_HALF_BIT] && (r.speed != MTXCI_SPD_1000);
    r.col_inject = c[`MTXCI_CTRL_SLOT_BIT];
    decode_cfg = r;
  endfunction

  assign cfg0 = decode_cfg(s_reg.ctrl0);
  assign cfg1 = decode_cfg(s_reg.ctrl1);

  // Each instance has its own client port and engine; the bus and the interrupt status and mask are shared.
  mtxci_engine u_mac_instance_zero (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .cfg_in(cfg0),
    .client_in(tx_client0_in),
    .answer_out(tx_answer0_out),
    .line_out(tx_line0_out),
    .line_clk_out(tx_line_clk0_out),
    .done_out(done0),
    .abort_out(abort0),
    .busy_out(busy0)
  );
  mtxci_engine u_mac_instance_one (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .cfg_in(cfg1),
    .client_in(tx_client1_in),
    .answer_out(tx_answer1_out),
    .line_out(tx_line1_out),
    .line_clk_out(tx_line_clk1_out),
    .done_out(done1),
    .abort_out(abort1),
    .busy_out(busy1)
  );

  always_comb begin
    events = '0;
    events[`MTXCI_EV_DONE0] = done0;
    events[`MTXCI_EV_ABORT0] = abort0;
    events[`MTXCI_EV_DONE1] = done1;
    events[`MTXCI_EV_ABORT1] = abort1;
  end

  always_comb begin
    s_next = s_reg;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    if (psel && !penable) begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h0000_0000;
      unique case (paddr)
        `MTXCI_OFF_CTRL0: s_next.prdata = {24'h000000, s_reg.ctrl0};
        `MTXCI_OFF_CTRL1: s_next.prdata = {24'h000000, s_reg.ctrl1};
        `MTXCI_OFF_STAT0: s_next.prdata = {31'h00000000, busy0};
        `MTXCI_OFF_STAT1: s_next.prdata = {31'h00000000, busy1};
        `MTXCI_OFF_IRQ: s_next.prdata = {28'h0000000, s_reg.irq_stat};
        `MTXCI_OFF_MASK: s_next.prdata = {28'h0000000, s_reg.irq_mask};
        default: s_next.pslverr = 1'b1;
      endcase
    end
    // Writes land at the access edge, one cycle after setup, when pready is already high.
    if (psel && penable && pwrite && s_reg.pready) begin
      unique case (paddr)
        `MTXCI_OFF_CTRL0: s_next.ctrl0 = pwdata[7:0];
        `MTXCI_OFF_CTRL1: s_next.ctrl1 = pwdata[7:0];
        `MTXCI_OFF_IRQ: s_next.irq_stat = s_reg.irq_stat & ~pwdata[`MTXCI_IRQ_BITS-1:0];
        `MTXCI_OFF_MASK: s_next.irq_mask = pwdata[`MTXCI_IRQ_BITS-1:0];
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    s_next.irq_stat = s_next.irq_stat | events;
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign irq_out = s_reg.irq;
endmodule // mtxci_top

// file: dv/mtxci_monitor.sv
`timescale 1ns/1ns
module mtxci_monitor
  import mtxci_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire mtxci_client_t tx_client0_in,
  input wire mtxci_answer_t tx_answer0_out,
  input wire mtxci_answer_t tx_answer1_out,
  input wire mtxci_line_t tx_line0_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ready;
    psel && penable && pready;
  endsequence
  apb_answer_a: assert property (s_setup |=> s_ready)
    else $error("Access not answered.");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("Ready held too long.");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("Error without ready.");
  ack_pulse_a: assert property (tx_answer0_out.ack |=> !tx_answer0_out.ack)
    else $error("Accept held too long.");
  ack_cause_a: assert property (tx_answer0_out.ack |-> $past(tx_client0_in.valid))
    else $error("Accept without valid.");
  ack_line_a: assert property (tx_answer0_out.ack |=> tx_line0_out.en)
    else $error("First byte not sent.");
  col_pair_a: assert property (tx_answer0_out.collision == tx_answer0_out.resend)
    else $error("Collision unpaired.");
  col_pair1_a: assert property (tx_answer1_out.collision == tx_answer1_out.resend)
    else $error("Collision unpaired.");
  abort_err_a: assert property (tx_client0_in.abort && tx_line0_out.en |-> ##[0:4] tx_line0_out.err)
    else $error("Underrun not marked.");
endmodule // mtxci_monitor
bind mtxci_top mtxci_monitor mtxci_monitor_inst (.clk_sys_in, .reset_in, .psel, .penable, .pready, .pslverr,
  .tx_client0_in, .tx_answer0_out, .tx_answer1_out, .tx_line0_out);

// file: dv/mtxci_client_model.sv
`timescale 1ns/1ns
module mtxci_client_model
  import mtxci_pkg::*;
(
  input wire logic clk_sys_in,
  input wire mtxci_answer_t answer_in,
  output mtxci_client_t client_out
);
  logic [7:0] sent_q[$];
  int misses = 0;
  // Odd and first stay low and gap adjust stays zero for 8-bit frames.
  initial client_out = '0;
  task automatic send(input int len, input int ab, input logic [7:0] sd, input bit wd, input bit od);
    int n;
    logic [7:0] b;
    bit last;
    sent_q = {};
    @(posedge clk_sys_in);
    for (int i = 0; i < len && answer_in.collision !== 1'b1; i++) begin
      b = sd ^ 8'(i * 29);
      last = wd && od && (i == len - 1);
      client_out.data <= {~b, b};
      client_out.odd <= last;
      client_out.valid <= 1'b1;
      client_out.abort <= 1'(i == ab);
      sent_q.push_back(b);
      if (wd && !last) sent_q.push_back(~b);
      n = 0;
      // A wide word after the first is held two edges while the high byte goes out.
      do begin
        @(posedge clk_sys_in);
        n++;
      end while ((i == 0 && answer_in.ack !== 1'b1 && n < 64) || (wd && i > 0 && n < 2));
      if (i == 0 && answer_in.ack !== 1'b1) misses++;
    end
    // Released data shows the inverse so a stale byte cannot pass.
    client_out.data <= ~client_out.data;
    client_out.odd <= 1'b0;
    client_out.valid <= 1'b0;
    client_out.abort <= 1'b0;
  endtask
endmodule // mtxci_client_model

// file: dv/mtxci_top_tb.sv
`timescale 1ns/1ns
module mtxci_top_tb
  import mtxci_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, rng = 32'h0000_F462;
  logic pready, pslverr, irq_out, er, err0, col0;
  mtxci_client_t cl0, cl1;
  mtxci_answer_t an0, an1;
  mtxci_line_t ln0, ln1;
  logic [7:0] got0[$], got1[$];
  int num_errors = 0;
  int comparisons = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  mtxci_top mtxci_top_inst (.clk_sys_in, .reset_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_client0_in(cl0), .tx_client1_in(cl1), .tx_answer0_out(an0), .tx_answer1_out(an1),
    .tx_line0_out(ln0), .tx_line1_out(ln1), .tx_line_clk0_out(), .tx_line_clk1_out(), .irq_out);
  mtxci_client_model mtxci_client_model_inst (.clk_sys_in, .answer_in(an0), .client_out(cl0));
  mtxci_client_model mtxci_client_model_inst1 (.clk_sys_in, .answer_in(an1), .client_out(cl1));
  always @(posedge clk_sys_in) begin
    if (ln0.en === 1'b1) got0.push_back(ln0.data);
    if (ln1.en === 1'b1) got1.push_back(ln1.data);
    if (ln0.err === 1'b1) err0 <= 1'b1;
    if (an0.collision === 1'b1) col0 <= 1'b1;
  end
  task automatic end_sim();
    $display("Counts: %0d compares, %0d errors", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frames(input int ab, input logic [31:0] m, input bit wd, input bit od, input int base);
    int n;
    got0 = {};
    got1 = {};
    err0 = 1'b0;
    col0 = 1'b0;
    rng = xs(rng);
    fork
      mtxci_client_model_inst.send(base + int'(rng[2:0]), ab, rng[15:8], 1'b0, 1'b0);
      mtxci_client_model_inst1.send(base + int'(rng[2:0]), -1, rng[23:16], wd, od);
    join
    check(32'(mtxci_client_model_inst.misses + mtxci_client_model_inst1.misses), 32'h0000_0000);
    n = 0;
    do begin
      apb(1'b0, 8'h10, 32'h0000_0000);
      n++;
    end while ((rd & m) !== m && n < 40);
    check(rd & m, m);
  endtask
  task automatic cmpq(ref logic [7:0] g[$], ref logic [7:0] e[$]);
    check(32'(g.size()), 32'(e.size()));
    foreach (e[i]) check(32'(g[i]), 32'(e[i]));
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    apb(1'b0, 8'h14, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0008);
    apb(1'b1, 8'h04, 32'h0000_0009);
    apb(1'b0, 8'h04, 32'h0000_0000);
    check(rd, 32'h0000_0009);
    apb(1'b0, 8'h18, 32'h0000_0000);
    check(32'(er), 32'h0000_0001);
    $display("Test registers done.");
    // The wide bit outside PCS mode must still give an 8-bit stream.
    frames(-1, 32'h0000_0005, 1'b0, 1'b0, 4);
    cmpq(got0, mtxci_client_model_inst.sent_q);
    cmpq(got1, mtxci_client_model_inst1.sent_q);
    check(32'(irq_out), 32'h0000_0000);
    apb(1'b1, 8'h14, 32'h0000_0005);
    repeat (2) @(posedge clk_sys_in);
    check(32'(irq_out), 32'h0000_0001);
    apb(1'b1, 8'h10, 32'h0000_0005);
    apb(1'b1, 8'h14, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    $display("Test frames done.");
    frames(2, 32'h0000_0002, 1'b0, 1'b0, 4);
    check(32'(err0), 32'h0000_0001);
    apb(1'b1, 8'h10, 32'h0000_000F);
    $display("Test underrun done.");
    // Wide PCS mode on the second instance, with a random odd last transfer.
    apb(1'b1, 8'h04, 32'h0000_0049);
    frames(-1, 32'h0000_0004, 1'b1, rng[24], 4);
    cmpq(got1, mtxci_client_model_inst1.sent_q);
    cmpq(got0, mtxci_client_model_inst.sent_q);
    apb(1'b1, 8'h10, 32'h0000_000F);
    $display("Test wide done.");
    // Half duplex at 10 Mb/s with the collision test injection on the first instance.
    apb(1'b1, 8'h00, 32'h0000_0082);
    frames(-1, 32'h0000_0002, 1'b1, 1'b0, 80);
    check(32'(col0), 32'h0000_0001);
    cmpq(got1, mtxci_client_model_inst1.sent_q);
    apb(1'b1, 8'h10, 32'h0000_000F);
    $display("Test collision done.");
    end_sim();
  end
endmodule // mtxci_top_tb
